/* shared/dmpr_pkg.sv */
// Package for the calibration pattern read and loop-off mode block.
// Assumes a DDR3 style command bus sampled by the core clock, and a
// small local register port driven by logic on core_clk_i.
package dmpr_pkg;

   // Local register port offsets (word index on reg_addr_i)
   localparam logic [2:0] REG_CTRL     = 3'h0;  // Control: lane fill mode
   localparam logic [2:0] REG_RSV_PAT  = 3'h1;  // Data for reserved locations
   localparam logic [2:0] REG_STATUS   = 3'h2;  // Mode and burst state
   localparam logic [2:0] REG_LATENCY  = 3'h3;  // Current read latency in CK

   // Control register fields and reset values
   localparam int         CTRL_REPL_BIT   = 0;      // 1: bits 7..1 copy bit 0
   localparam logic [7:0] CTRL_RESET      = 8'h01;
   localparam logic [7:0] RSV_PAT_RESET   = 8'h00;

   // Status register field positions
   localparam int ST_CAL_EN   = 0;  // Calibration reads enabled
   localparam int ST_LOOP_OFF = 1;  // Delay-locked loop disabled
   localparam int ST_LAT_OK   = 2;  // Loop-off latency pairing is 6 and 6
   localparam int ST_BUSY     = 3;  // Burst pending or driving before its last beat

   // Mode register field positions (address bits of the mode write)
   localparam int MR0_BL_LO   = 0;   // Burst length field, 2 bits
   localparam int MR0_CL_LO   = 4;   // CAS latency code, 3 bits
   localparam int MR1_LOOPOFF = 0;   // Loop disable bit
   localparam int MR1_AL_LO   = 3;   // Additive latency, 2 bits
   localparam int MR2_CWL_LO  = 3;   // CAS write latency code, 3 bits
   localparam int MR3_LOC_LO  = 0;   // Pattern location select, 2 bits
   localparam int MR3_CAL_EN  = 2;   // Calibration read enable
   localparam logic [12:0] MR_RESET = 13'h0000;

   // Latency code offsets and the only pairing needed in loop-off mode
   localparam logic [3:0] CL_BASE      = 4'h4;
   localparam logic [3:0] CWL_BASE     = 4'h5;
   localparam logic [3:0] LOOP_OFF_CL  = 4'h6;
   localparam logic [3:0] LOOP_OFF_CWL = 4'h6;

   // Burst length encodings in mode register 0
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF    = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;

   // Predefined pattern: beat 0 in the LSB, alternating 0,1
   localparam logic [7:0] CAL_PATTERN = 8'hAA;
   localparam logic [1:0] LOC_PREDEF  = 2'h0;

   // Last beat index for full and chopped bursts
   localparam logic [2:0] LAST_BL8 = 3'h7;
   localparam logic [2:0] LAST_BC4 = 3'h3;

   // Mode register select codes on the bank address
   localparam logic [1:0] MRS_MR0 = 2'h0;
   localparam logic [1:0] MRS_MR1 = 2'h1;
   localparam logic [1:0] MRS_MR2 = 2'h2;
   localparam logic [1:0] MRS_MR3 = 2'h3;

   // Decoded commands
   typedef enum logic [1:0] {DMPR_CMD_NONE, DMPR_CMD_MRS, DMPR_CMD_READ} dmpr_cmd_t;

endpackage : dmpr_pkg

/* logic/dmpr_sync.sv */
// Two-flop synchroniser for a bundle of inputs from another domain.
// Assumes the bits need no mutual coherence beyond being stable for
// several core clock cycles around the edges that consume them.
module dmpr_sync #(
   parameter int W = 1  // Number of bits carried
) (
   // Clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         nrst_i,
   // Data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_q;  // First stage, read only by the second
   logic [W-1:0] sync_q;  // Second stage

   // Two register stages, constant reset
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule : dmpr_sync

/* logic/dmpr_dev.sv */
// Device-side command logic: mode writes, calibration pattern reads and
// loop-off read latency, as seen on a DDR3 style pin bus.
// Assumes CK and the command pins are slow against core_clk_i; CK edges are found by sampling.
//
// Chosen here: the register offsets and strobed register access.

module dmpr_dev #(
   parameter int PIPE_W = 32  // Depth of the read latency pipeline in CK
) (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   // Link pins from the memory controller
   input  wire logic        ck_i,
   input  wire logic        cke_i,
   input  wire logic        cs_n_i,
   input  wire logic        ras_n_i,
   input  wire logic        cas_n_i,
   input  wire logic        we_n_i,
   input  wire logic [2:0]  bank_i,
   input  wire logic [12:0] addr_i,
   // Data pins back to the controller
   output logic      [7:0]  lower_byte_lane_o,
   output logic      [7:0]  upper_byte_lane_o,
   output logic             dq_oe_o,
   output logic             dqs_o,
   output logic             dqs_oe_o,
   // Local register port
   input  wire logic [2:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_we_i,
   input  wire logic        reg_re_i,
   output logic      [7:0]  reg_rdata_o
);

   // Latency can reach 21 CK; the pipeline must hold it
   if (PIPE_W < 24 || PIPE_W > 64) begin : g_pipe_w_bad
      $error("dmpr_dev: PIPE_W must be 24..64");
   end

   localparam int SW = 22;  // Synchronised pin count
   logic [SW-1:0] pins_s;                       // Synchronised pins
   logic          ck_s;                         // Sampled link clock
   logic          cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s;
   logic [2:0]    bank_s;                       // Bank address
   logic [12:0]   addr_s;                       // Address bits

   // All link pins pass two flops before use
   dmpr_sync #(.W(SW)) u_sync (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .async_i    ({ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, bank_i, addr_i}),
      .sync_o     (pins_s)
   );

   assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, bank_s, addr_s} = pins_s;

   logic ck_prev_q, ck_prev_d;  // Previous sampled CK level
   logic ck_rise;     // Rising CK edge seen this cycle
   logic ck_fall;     // Falling CK edge seen this cycle

   // Edge finder next value
   always_comb begin
      ck_prev_d = ck_s;
   end

   // Edge finder register
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ck_prev_q <= 1'b0;
      end else begin
         ck_prev_q <= ck_prev_d;
      end
   end

   assign ck_rise = ck_s & ~ck_prev_q;
   assign ck_fall = ~ck_s & ck_prev_q;

   dmpr_pkg::dmpr_cmd_t cmd;  // Command taken at this CK rise

   // Decode at the CK rise; deselect and NOP yield nothing
   always_comb begin
      cmd = dmpr_pkg::DMPR_CMD_NONE;
      if (ck_rise && cke_s && !cs_n_s) begin
         if (!ras_n_s && !cas_n_s && !we_n_s) begin
            cmd = dmpr_pkg::DMPR_CMD_MRS;
         end else if (ras_n_s && !cas_n_s && we_n_s) begin
            cmd = dmpr_pkg::DMPR_CMD_READ;
         end else begin
            cmd = dmpr_pkg::DMPR_CMD_NONE;
         end
      end
   end

   logic [12:0] mr_q [4], mr_d [4];  // Mode registers 0..3

   // A mode write loads the register picked by bank bits 1..0
   always_comb begin
      mr_d = mr_q;
      if (cmd == dmpr_pkg::DMPR_CMD_MRS) begin
         mr_d[bank_s[1:0]] = addr_s;
      end
   end

   // Mode register storage
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mr_q <= '{default: dmpr_pkg::MR_RESET};
      end else begin
         mr_q <= mr_d;
      end
   end

   logic       cal_en;    // Pattern reads redirected
   logic       loop_off;  // Loop disabled
   logic [1:0] loc_sel;   // pattern_location_select
   logic [1:0] bl_mode;   // Burst length mode
   logic [3:0] cl;        // CAS latency in CK
   logic [3:0] cwl;       // CAS write latency in CK
   logic [4:0] al;        // Additive latency in CK
   logic [4:0] rl;        // Read latency used for data
   logic       lat_ok;    // Loop-off pairing satisfied

   assign cal_en   = mr_q[dmpr_pkg::MRS_MR3][dmpr_pkg::MR3_CAL_EN];
   assign loop_off = mr_q[dmpr_pkg::MRS_MR1][dmpr_pkg::MR1_LOOPOFF];
   assign loc_sel  = mr_q[dmpr_pkg::MRS_MR3][dmpr_pkg::MR3_LOC_LO +: 2];
   assign bl_mode  = mr_q[dmpr_pkg::MRS_MR0][dmpr_pkg::MR0_BL_LO +: 2];
   assign cl  = dmpr_pkg::CL_BASE + {1'b0, mr_q[dmpr_pkg::MRS_MR0][dmpr_pkg::MR0_CL_LO +: 3]};
   assign cwl = dmpr_pkg::CWL_BASE + {1'b0, mr_q[dmpr_pkg::MRS_MR2][dmpr_pkg::MR2_CWL_LO +: 3]};
   assign lat_ok = (cl == dmpr_pkg::LOOP_OFF_CL) && (cwl == dmpr_pkg::LOOP_OFF_CWL);

   // Additive latency: 0, CL-1 or CL-2; read latency one less with loop off
   always_comb begin
      unique case (mr_q[dmpr_pkg::MRS_MR1][dmpr_pkg::MR1_AL_LO +: 2])
         2'h1:    al = {1'b0, cl} - 5'h01;
         2'h2:    al = {1'b0, cl} - 5'h02;
         default: al = 5'h00;
      endcase
      rl = al + {1'b0, cl} - {4'h0, loop_off};
   end

   logic [PIPE_W-1:0] pend_q, nib_q, chop_q;  // Start flag, nibble, chop
   logic [PIPE_W-1:0] pend_d, nib_d, chop_d;
   logic              rd_chop;                // This read is chopped
   logic              rd_nib;                 // This read's nibble
   logic              start;                  // Burst starts at this CK rise

   // Chop from fixed setting or A12 when on the fly; A2 picks the nibble of a chopped read, other bits ignored
   always_comb begin
      unique case (bl_mode)
         dmpr_pkg::BL_OTF:    rd_chop = ~addr_s[12];
         dmpr_pkg::BL_FIXED4: rd_chop = 1'b1;
         default:             rd_chop = 1'b0;
      endcase
      rd_nib = rd_chop & addr_s[2];
   end

   // Shift one place each CK rise; a read with calibration reads enabled enters at its latency slot
   always_comb begin
      pend_d = pend_q;
      nib_d  = nib_q;
      chop_d = chop_q;
      if (ck_rise) begin
         pend_d = pend_q >> 1;
         nib_d  = nib_q >> 1;
         chop_d = chop_q >> 1;
         if (cmd == dmpr_pkg::DMPR_CMD_READ && cal_en) begin
            pend_d[rl] = 1'b1;
            nib_d[rl]  = rd_nib;
            chop_d[rl] = rd_chop;
         end
      end
   end

   // Pipeline registers
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pend_q <= '0;
         nib_q  <= '0;
         chop_q <= '0;
      end else begin
         pend_q <= pend_d;
         nib_q  <= nib_d;
         chop_q <= chop_d;
      end
   end

   assign start = ck_rise & pend_q[1];

   logic [7:0] rsv_pat_q;      // Data for reserved locations
   logic [7:0] ctrl_q;         // Control register
   logic [2:0] beat_q, beat_d; // Next beat index to drive
   logic [2:0] left_q, left_d; // Beats still to drive
   logic       act_q, act_d;   // Burst in progress
   logic [7:0] lo_q, lo_d;     // Lower lane data
   logic       oe_q, oe_d;     // Data and strobe enable
   logic       dqs_q, dqs_d;   // Strobe level
   logic [7:0] pat;            // Pattern of the chosen location
   logic [2:0] beat_now;       // Beat driven at this edge
   logic       bit0;           // Pattern bit for this beat

   assign pat = (loc_sel == dmpr_pkg::LOC_PREDEF) ? dmpr_pkg::CAL_PATTERN
                                                  : rsv_pat_q;
   assign beat_now = start ? {nib_q[1], 2'h0} : beat_q;
   assign bit0     = pat[beat_now];

   // One beat per CK edge; a new start may follow the last beat seamlessly
   always_comb begin
      beat_d = beat_q;
      left_d = left_q;
      act_d  = act_q;
      lo_d   = lo_q;
      oe_d   = oe_q;
      dqs_d  = dqs_q;
      if (ck_rise || ck_fall) begin
         if (start || act_q) begin
            // Lane fill: copy bit 0 or drive zero above it
            lo_d   = ctrl_q[dmpr_pkg::CTRL_REPL_BIT] ? {8{bit0}}
                                                     : {7'h00, bit0};
            oe_d   = 1'b1;
            dqs_d  = ck_rise;
            beat_d = beat_now + 3'h1;
            if (start) begin
               left_d = chop_q[1] ? dmpr_pkg::LAST_BC4 : dmpr_pkg::LAST_BL8;
               act_d  = 1'b1;
            end else begin
               left_d = left_q - 3'h1;
               act_d  = (left_q != 3'h1);
            end
         end else begin
            // Release the bus after the last beat
            oe_d  = 1'b0;
            dqs_d = 1'b0;
            lo_d  = 8'h00;
         end
      end
   end

   // Burst registers
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         beat_q <= 3'h0;
         left_q <= 3'h0;
         act_q  <= 1'b0;
         lo_q   <= 8'h00;
         oe_q   <= 1'b0;
         dqs_q  <= 1'b0;
      end else begin
         beat_q <= beat_d;
         left_q <= left_d;
         act_q  <= act_d;
         lo_q   <= lo_d;
         oe_q   <= oe_d;
         dqs_q  <= dqs_d;
      end
   end

   // Both lanes carry the same stream
   assign lower_byte_lane_o = lo_q;
   assign upper_byte_lane_o = lo_q;
   assign dq_oe_o           = oe_q;
   assign dqs_o             = dqs_q;
   assign dqs_oe_o          = oe_q;

   logic [7:0] ctrl_d;      // Control next value
   logic [7:0] rsv_pat_d;   // Reserved data next value
   logic [7:0] rdata_q, rdata_d;  // Read data, one cycle after the strobe
   logic [7:0] status;      // Live status word

   // Status word from mode and burst state
   always_comb begin
      status = 8'h00;
      status[dmpr_pkg::ST_CAL_EN]   = cal_en;
      status[dmpr_pkg::ST_LOOP_OFF] = loop_off;
      status[dmpr_pkg::ST_LAT_OK]   = lat_ok;
      status[dmpr_pkg::ST_BUSY]     = act_q | (|pend_q);
   end

   // Writes and read selection; unmapped reads return zero
   always_comb begin
      ctrl_d    = ctrl_q;
      rsv_pat_d = rsv_pat_q;
      rdata_d   = 8'h00;
      if (reg_we_i) begin
         unique case (reg_addr_i)
            dmpr_pkg::REG_CTRL:    ctrl_d    = {7'h00, reg_wdata_i[dmpr_pkg::CTRL_REPL_BIT]};
            dmpr_pkg::REG_RSV_PAT: rsv_pat_d = reg_wdata_i;
            default:               ;
         endcase
      end
      if (reg_re_i) begin
         unique case (reg_addr_i)
            dmpr_pkg::REG_CTRL:    rdata_d = ctrl_q;
            dmpr_pkg::REG_RSV_PAT: rdata_d = rsv_pat_q;
            dmpr_pkg::REG_STATUS:  rdata_d = status;
            dmpr_pkg::REG_LATENCY: rdata_d = {3'h0, rl};
            default:               rdata_d = 8'h00;
         endcase
      end
   end

   // Register port storage
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q    <= dmpr_pkg::CTRL_RESET;
         rsv_pat_q <= dmpr_pkg::RSV_PAT_RESET;
         rdata_q   <= 8'h00;
      end else begin
         ctrl_q    <= ctrl_d;
         rsv_pat_q <= rsv_pat_d;
         rdata_q   <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

endmodule : dmpr_dev

/* verification/dmpr_dev_sva.sv */
// Checker for dmpr_dev: lane fill, strobe framing and register port.
// Assumes it is bound to dmpr_dev and sees only that module's ports.
module dmpr_dev_chk (
   // Clock and reset
   input wire logic       core_clk_i,
   input wire logic       nrst_i,
   // Data pins
   input wire logic [7:0] lower_byte_lane_o,
   input wire logic [7:0] upper_byte_lane_o,
   input wire logic       dq_oe_o,
   input wire logic       dqs_o,
   input wire logic       dqs_oe_o,
   // Register port
   input wire logic [2:0] reg_addr_i,
   input wire logic       reg_re_i,
   input wire logic [7:0] reg_rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);

   // Both lanes carry the same beat
   property p_lane_match;
      dq_oe_o |-> upper_byte_lane_o == lower_byte_lane_o;
   endproperty
   a_lane_match: assert property (p_lane_match)
      else $error("upper lane differs from lower lane");

   // Bits 7..1 copy bit 0 or stay zero
   property p_lane_fill;
      dq_oe_o |-> lower_byte_lane_o[7:1] == 7'h00 ||
                  lower_byte_lane_o[7:1] == {7{lower_byte_lane_o[0]}};
   endproperty
   a_lane_fill: assert property (p_lane_fill)
      else $error("lane bits 7..1 neither copy nor zero");

   // Strobe is driven exactly while data is driven
   property p_strobe_en;
      dqs_oe_o == dq_oe_o;
   endproperty
   a_strobe_en: assert property (p_strobe_en)
      else $error("strobe enable differs from data enable");

   // Beat 0 goes out on a rising CK edge
   property p_first_rise;
      $rose(dq_oe_o) |-> dqs_o;
   endproperty
   a_first_rise: assert property (p_first_rise)
      else $error("first beat not on a rise");

   // A burst ends after a falling beat, so beats come in whole pairs
   property p_last_fall;
      $fell(dq_oe_o) |-> !$past(dqs_o);
   endproperty
   a_last_fall: assert property (p_last_fall)
      else $error("burst ended on a rising beat");

   // Each beat stands for a CK half period
   property p_beat_hold;
      dq_oe_o && $changed(dqs_o) |=> $stable(dqs_o) [*2];
   endproperty
   a_beat_hold: assert property (p_beat_hold)
      else $error("beat shorter than half a CK period");

   // Quiet pins when not driving
   property p_quiet;
      !dq_oe_o |-> lower_byte_lane_o == 8'h00 && !dqs_o;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("lanes not quiet while undriven");

   // Read data stands only in the cycle after a read strobe
   property p_rdata_gap;
      !$past(reg_re_i) |-> reg_rdata_o == 8'h00;
   endproperty
   a_rdata_gap: assert property (p_rdata_gap)
      else $error("read data without a read strobe");

   // Unmapped offsets read as zero
   property p_unmapped;
      reg_re_i && reg_addr_i[2] |=> reg_rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped offset returned data");

endmodule : dmpr_dev_chk

bind dmpr_dev dmpr_dev_chk chk_u (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i),
   .lower_byte_lane_o(lower_byte_lane_o), .upper_byte_lane_o(upper_byte_lane_o),
   .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o),
   .reg_addr_i(reg_addr_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o)
);

/* verification/dmpr_ctl_model.sv */
// Memory controller model: runs CK, issues mode writes and reads, and
// the loop-off switch through self refresh. Driven by testbench calls.
module dmpr_ctl_model #(
   parameter int MOD_CK = 12  // Mode write to next command, in CK
) (
   // Link pins
   output logic        ck_o,
   output logic        cke_o,
   output logic [3:0]  cmd_o,   // cs_n, ras_n, cas_n, we_n
   output logic [2:0]  bank_o,
   output logic [12:0] addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ck_run;    // Clock gate, low only inside self refresh
   int   ck_rises;  // CK rising edges so far
   int   rd_rise;   // CK rise that takes the last read

   // Pin values at time zero, then a free 200 ns CK, well under max rate
   initial begin
      ck_o = 1'b0;
      cke_o = 1'b1;
      cmd_o = 4'h7;
      bank_o = 3'h0;
      addr_o = 13'h0000;
      ck_run = 1'b1;
      ck_rises = 0;
      rd_rise = 0;
      #37;
      forever #100 if (ck_run) ck_o = ~ck_o;
   end

   // Count rises to measure read latency
   always @(posedge ck_o) ck_rises <= ck_rises + 1;

   // One command on one CK rise, then NOP with moving address bits
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
      @(negedge ck_o);
      cmd_o <= c;
      bank_o <= b;
      addr_o <= a;
      if (c == 4'h5) rd_rise <= ck_rises + 1;
      @(negedge ck_o);
      cmd_o <= 4'h7;
      addr_o <= ~a;
   endtask : issue

   // Mode write, then wait out its delay
   task automatic mrs(input logic [1:0] n, input logic [12:0] a);
      issue(4'h0, {1'b0, n}, a);
      repeat (MOD_CK) @(negedge ck_o);
   endtask : mrs

   // Other mode writes only with pattern reads switched off
   task automatic mrs_cal_off(input logic [1:0] n, input logic [12:0] a, input logic [12:0] m3);
      mrs(2'h3, 13'h0000);
      mrs(n, a);
      mrs(2'h3, m3);
   endtask : mrs_cal_off

   // Pattern read: low column bits zero, junk in ignored bits
   task automatic rd(input logic a12, input logic a2);
      issue(4'h5, 3'h5, {a12, 9'h1FF, a2, 2'h0});
   endtask : rd

   // Loop-off switch from idle, through self refresh and a clock stop
   task automatic loop_off(input logic [12:0] mr1);
      mrs(2'h1, mr1);
      @(negedge ck_o);
      cke_o <= 1'b0;
      cmd_o <= 4'h1;
      repeat (5) @(negedge ck_o);
      cmd_o <= 4'h7;
      ck_run = 1'b0;
      #2000;
      ck_run = 1'b1;
      repeat (5) @(negedge ck_o);
      cke_o <= 1'b1;
      repeat (MOD_CK) @(negedge ck_o);
      mrs(2'h0, 13'h0021);
      mrs(2'h2, 13'h0008);
   endtask : loop_off
endmodule : dmpr_ctl_model

/* verification/tb_dmpr_dev.sv */
// Testbench: pattern reads, burst order, NOP and deselect, loop-off
// latency. Assumes dmpr_dev, the controller model and the checker.
`define CHK(got, exp) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp); \
   end \
end

module tb_dmpr_dev;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i = 1'b0;  // Core clock, 25 ns
   logic        nrst_i = 1'b0;      // Reset, active low
   logic        ck, cke;            // Link clock and clock enable
   logic [3:0]  cmd;                // cs_n, ras_n, cas_n, we_n
   logic [2:0]  bank;
   logic [12:0] addr;
   logic [7:0]  lower, upper;       // Byte lanes
   logic        dq_oe, dqs, dqs_oe;
   logic [2:0]  reg_addr = 3'h0;    // Register port
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_we = 1'b0;
   logic        reg_re = 1'b0;
   logic [7:0]  reg_rdata;
   int          mismatches = 0;
   int          n_tests = 0;
   logic [7:0]  beats[$];           // Captured beats
   logic        oe_q = 1'b0;
   logic        dqs_q = 1'b0;
   int          lat = 0;            // CK rises from read to beat 0

   always #12.5 core_clk_i = ~core_clk_i;

   dmpr_dev dut_u (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ck_i(ck), .cke_i(cke),
      .cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]),
      .bank_i(bank), .addr_i(addr), .lower_byte_lane_o(lower),
      .upper_byte_lane_o(upper), .dq_oe_o(dq_oe), .dqs_o(dqs), .dqs_oe_o(dqs_oe),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
      .reg_re_i(reg_re), .reg_rdata_o(reg_rdata)
   );

   dmpr_ctl_model model_u (
      .ck_o(ck), .cke_o(cke), .cmd_o(cmd), .bank_o(bank), .addr_o(addr)
   );

   // One beat per strobe change while lanes are driven
   always @(posedge core_clk_i) begin
      oe_q <= dq_oe;
      dqs_q <= dqs;
      if (dq_oe && !oe_q) lat <= model_u.ck_rises - model_u.rd_rise;
      if (dq_oe && (!oe_q || dqs != dqs_q)) beats.push_back(lower);
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge core_clk_i);
      reg_we <= 1'b0;
   endtask : wr

   // Read and compare in the one cycle the data stands
   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge core_clk_i);
      reg_re <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rchk

   // One read; check beat count, latency and each beat's bit and fill
   task automatic burst(input logic a12, a2, extra, input int n, rl,
                        input logic [7:0] pat, input logic fill);
      int k;
      int s;
      logic [7:0] e;
      beats.delete();
      s = (n == 4 && a2) ? 4 : 0;
      model_u.rd(a12, a2);
      if (extra) begin
         model_u.issue(4'hD, 3'h0, 13'h0000);  // Deselect carrying a read code
         model_u.issue(4'h7, 3'h0, 13'h1FFF);  // NOP
      end
      k = 0;
      while (beats.size() < n && k < 3000) begin
         @(posedge core_clk_i);
         k++;
      end
      if (k >= 3000) begin
         mismatches++;
         final_report();
      end
      repeat (100) @(posedge core_clk_i);
      `CHK(beats.size(), n)
      if (n > 0) `CHK(lat, rl)
      for (k = 0; k < n && k < beats.size(); k++) begin
         e = fill ? {8{pat[s+k]}} : {7'h00, pat[s+k]};
         `CHK(beats[k], e)
      end
      $display("test burst done");
   endtask : burst

   // Main sequence
   initial begin
      repeat (10) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      rchk(dmpr_pkg::REG_CTRL, dmpr_pkg::CTRL_RESET);
      rchk(dmpr_pkg::REG_RSV_PAT, dmpr_pkg::RSV_PAT_RESET);
      rchk(dmpr_pkg::REG_LATENCY, 8'h04);
      wr(dmpr_pkg::REG_STATUS, 8'hFF);
      rchk(dmpr_pkg::REG_STATUS, 8'h00);
      rchk(3'h5, 8'h00);
      wr(dmpr_pkg::REG_RSV_PAT, 8'h1D);
      rchk(dmpr_pkg::REG_RSV_PAT, 8'h1D);
      $display("test registers done");
      burst(1'b0, 1'b0, 1'b0, 0, 0, 8'h00, 1'b1);
      model_u.mrs(2'h3, 13'h0004);
      rchk(dmpr_pkg::REG_STATUS, 8'h01);
      burst(1'b0, 1'b0, 1'b0, 8, 4, dmpr_pkg::CAL_PATTERN, 1'b1);
      wr(dmpr_pkg::REG_CTRL, 8'h00);
      rchk(dmpr_pkg::REG_CTRL, 8'h00);
      model_u.mrs_cal_off(2'h0, 13'h0021, 13'h0004);
      burst(1'b0, 1'b1, 1'b0, 4, 6, dmpr_pkg::CAL_PATTERN, 1'b0);
      for (int loc = 1; loc < 4; loc++) begin
         model_u.mrs_cal_off(2'h3, 13'h0000, 13'h0004 | 13'(loc));
         burst(1'b0, 1'b0, 1'b0, 4, 6, 8'h1D, 1'b0);
         burst(1'b0, 1'b1, 1'b0, 4, 6, 8'h1D, 1'b0);
         burst(1'b1, 1'b0, 1'b1, 8, 6, 8'h1D, 1'b0);
      end
      model_u.mrs_cal_off(2'h0, 13'h0022, 13'h0005);
      burst(1'b1, 1'b1, 1'b0, 4, 6, 8'h1D, 1'b0);
      model_u.mrs(2'h3, 13'h0000);
      model_u.loop_off(13'h0009);
      model_u.mrs(2'h3, 13'h0005);
      rchk(dmpr_pkg::REG_STATUS, 8'h07);
      rchk(dmpr_pkg::REG_LATENCY, 8'h0A);
      burst(1'b1, 1'b0, 1'b0, 8, 10, 8'h1D, 1'b0);
      model_u.mrs_cal_off(2'h1, 13'h0000, 13'h0005);
      rchk(dmpr_pkg::REG_STATUS, 8'h05);
      burst(1'b1, 1'b0, 1'b0, 8, 6, 8'h1D, 1'b0);
      model_u.mrs_cal_off(2'h1, 13'h0010, 13'h0005);
      rchk(dmpr_pkg::REG_LATENCY, 8'h0A);
      $display("test loop off done");
      final_report();
   end
endmodule : tb_dmpr_dev
